// *** rtl/sfwle_pkg.sv ***
// package: constants of the serial flash write latch and erase logic
// Notes on behaviour
// - write enable code 06h sets latch
// - write disable code 04h clears latch
// - codes on one, two or four lanes
// - write enable without select rise ignored
// - write disable without select rise ignored
// - subsector erase: code plus three address bytes
// - sector erase: code plus three address bytes
// - address bits taken on clock rise
// - erase starts at select rise, self-timed
// - no select rise after frame: nothing happens
// - latch clear: erase ignored, no flags
// - busy bit high, latch cleared on start
// - busy bit low when erase ends
// - timeout clears latch, sets erase error
// - protected target: refuse, set bits 1,5
// - bulk refused when any sector locked
// - bulk erase is code only
// - status and flag status always readable
// - suspend and resume for (sub)sector erase
// - resume sets busy, clears ready; else ignored
package sfwle_pkg;
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_SSE_DEF = 8'h20;
	localparam logic [7:0] CMD_SE_DEF = 8'hd8;
	localparam logic [7:0] CMD_BE_DEF = 8'hc7;
	localparam logic [7:0] CMD_SUSP_DEF = 8'h75;
	localparam logic [7:0] CMD_RESM_DEF = 8'h7a;
	localparam logic [5:0] BITS_CODE = 6'h08;
	localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
	localparam logic [1:0] PROTO_EXT = 2'h0;
	localparam logic [1:0] PROTO_DUAL = 2'h1;
	localparam logic [1:0] PROTO_QUAD = 2'h2;
	localparam int FLAG_READY_BIT = 7;
	localparam int FLAG_ESUSP_BIT = 6;
	localparam int FLAG_EERR_BIT = 5;
	localparam int FLAG_PROT_BIT = 1;
	localparam int STAT_WIP_BIT = 0;
	localparam int STAT_WEL_BIT = 1;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SSE_TIME_US = 800000;
	localparam int SE_TIME_US = 3000000;
	localparam int BE_TIME_US = 60000000;
	typedef enum logic [1:0] {
		ER_SUB,
		ER_SEC,
		ER_BULK
	} sfwle_kind_e;
	typedef enum {
		ST_IDLE,
		ST_ERASE,
		ST_SUSP
	} sfwle_state_e;
endpackage : sfwle_pkg

// *** rtl/sfwle_sync.sv ***
// two-flop synchroniser for pins
`timescale 1ns/1ns
module sfwle_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '1;
			sync_o <= '1;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : sfwle_sync

// *** rtl/sfwle_top.sv ***
// write enable latch, erase commands and erase timing of the serial flash
`timescale 1ns/1ns
module sfwle_top #(
	parameter logic [7:0] CMD_SSE = sfwle_pkg::CMD_SSE_DEF,
	parameter logic [7:0] CMD_SE = sfwle_pkg::CMD_SE_DEF,
	parameter logic [7:0] CMD_BE = sfwle_pkg::CMD_BE_DEF,
	parameter logic [7:0] CMD_SUSP = sfwle_pkg::CMD_SUSP_DEF,
	parameter logic [7:0] CMD_RESM = sfwle_pkg::CMD_RESM_DEF,
	parameter int SSE_LIMIT_US = sfwle_pkg::SSE_TIME_US,
	parameter int SE_LIMIT_US = sfwle_pkg::SE_TIME_US,
	parameter int BE_LIMIT_US = sfwle_pkg::BE_TIME_US
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic sel_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] serial_lane_i,
	input wire logic [1:0] protocol_i,
	input wire logic target_protected_i,
	input wire logic any_sector_locked_i,
	input wire logic array_done_i,
	input wire logic clear_flags_i,
	output logic erase_start_o,
	output logic [1:0] erase_kind_o,
	output logic [23:0] erase_addr_o,
	output logic erase_hold_o,
	output logic [23:0] frame_addr_o,
	output logic [7:0] status_o,
	output logic [7:0] flag_status_o
);
	logic [5:0] pins_s;
	logic sel_n_s;
	logic sclk_s;
	logic [3:0] lane_s;
	logic sel_n_q;
	logic sclk_q;
	logic [31:0] shift_q;
	logic [31:0] shift_d;
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic wel_q;
	logic eerr_q;
	logic perr_q;
	logic esusp_q;
	logic [3:0] tick_q;
	logic [31:0] us_q;
	logic [31:0] limit_q;
	sfwle_pkg::sfwle_state_e st_q;

	// pins cross into the clock domain before anything looks at them
	sfwle_sync #(
		.WIDTH(6)
	) u_sync (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.async_i({sel_n_i, sclk_i, serial_lane_i}),
		.sync_o(pins_s)
	);
	assign sel_n_s = pins_s[5];
	assign sclk_s = pins_s[4];
	assign lane_s = pins_s[3:0];

	wire sclk_rise = sclk_s & ~sclk_q & ~sel_n_s;
	wire sel_rise = sel_n_s & ~sel_n_q;
	// lane count per protocol
	wire is_dual = (protocol_i == sfwle_pkg::PROTO_DUAL);
	wire is_quad = (protocol_i == sfwle_pkg::PROTO_QUAD);
	wire [5:0] step = is_quad ? 6'h04 : (is_dual ? 6'h02 : 6'h01);
	wire [31:0] shift_ext = {shift_q[30:0], lane_s[0]};
	wire [31:0] shift_dual = {shift_q[29:0], lane_s[1:0]};
	wire [31:0] shift_quad = {shift_q[27:0], lane_s[3:0]};
	wire [31:0] shift_new = is_quad ? shift_quad : (is_dual ? shift_dual : shift_ext);
	// count saturates so a long frame never wraps back onto a legal length
	wire cnt_full = (cnt_q > 6'h38);

	always_comb begin
		shift_d = shift_q;
		cnt_d = cnt_q;
		if (sel_n_s) begin
			cnt_d = 6'h00;
		end else if (sclk_rise) begin
			shift_d = shift_new;
			cnt_d = cnt_full ? cnt_q : 6'(cnt_q + step);
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_n_q <= 1'b1;
			sclk_q <= 1'b0;
			shift_q <= 32'h0000_0000;
			cnt_q <= 6'h00;
		end else begin
			sel_n_q <= sel_n_s;
			sclk_q <= sclk_s;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
		end
	end

	// a command counts only if select rises exactly at its length
	wire frame8 = sel_rise & (cnt_q == sfwle_pkg::BITS_CODE);
	wire frame32 = sel_rise & (cnt_q == sfwle_pkg::BITS_ADDR_CMD);
	wire [7:0] code8 = shift_q[7:0];
	wire [7:0] code32 = shift_q[31:24];
	wire idle = (st_q == sfwle_pkg::ST_IDLE);
	wire susp = (st_q == sfwle_pkg::ST_SUSP);
	wire busy = (st_q == sfwle_pkg::ST_ERASE);
	// write enable and disable stay legal while an erase is suspended
	wire do_wren = frame8 & (code8 == sfwle_pkg::CMD_WREN) & ~busy;
	wire do_wrdi = frame8 & (code8 == sfwle_pkg::CMD_WRDI) & ~busy;
	wire req_sse = frame32 & (code32 == CMD_SSE) & idle;
	wire req_se = frame32 & (code32 == CMD_SE) & idle;
	wire req_be = frame8 & (code8 == CMD_BE) & idle;
	wire req_any = (req_sse | req_se | req_be) & wel_q;
	wire refuse = ((req_sse | req_se) & target_protected_i) | (req_be & any_sector_locked_i);
	wire start = req_any & ~refuse;
	wire bad = req_any & refuse;
	// only sector and subsector erases may be paused
	wire can_susp = busy & (erase_kind_o != 2'(sfwle_pkg::ER_BULK));
	// an erase that ends in the same cycle completes instead of pausing
	wire do_susp = frame8 & (code8 == CMD_SUSP) & can_susp & ~array_done_i & ~(us_q >= limit_q);
	wire do_resm = frame8 & (code8 == CMD_RESM) & susp;
	wire tick = (tick_q == 4'(sfwle_pkg::TICK_CYC - 1));
	wire timeout = busy & (us_q >= limit_q);
	wire finish = busy & array_done_i & ~timeout;
	wire [31:0] lim_sel = req_be ? 32'(BE_LIMIT_US) : (req_se ? 32'(SE_LIMIT_US) : 32'(SSE_LIMIT_US));
	wire [1:0] kind_sel = req_be ? 2'(sfwle_pkg::ER_BULK) : (req_se ? 2'(sfwle_pkg::ER_SEC) : 2'(sfwle_pkg::ER_SUB));

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= sfwle_pkg::ST_IDLE;
		end else begin
			case (st_q)
				sfwle_pkg::ST_IDLE: begin
					if (start) begin
						st_q <= sfwle_pkg::ST_ERASE;
					end
				end
				sfwle_pkg::ST_ERASE: begin
					if (finish | timeout) begin
						st_q <= sfwle_pkg::ST_IDLE;
					end else if (do_susp) begin
						st_q <= sfwle_pkg::ST_SUSP;
					end
				end
				sfwle_pkg::ST_SUSP: begin
					if (do_resm) begin
						st_q <= sfwle_pkg::ST_ERASE;
					end
				end
				default: begin
					st_q <= sfwle_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// write enable latch: refusals leave it untouched
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wel_q <= 1'b0;
		end else if (start | timeout | do_wrdi) begin
			wel_q <= 1'b0;
		end else if (do_wren) begin
			wel_q <= 1'b1;
		end
	end

	// error flags: a set in the clearing cycle wins
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			eerr_q <= 1'b0;
			perr_q <= 1'b0;
		end else begin
			eerr_q <= (eerr_q & ~clear_flags_i) | bad | timeout;
			perr_q <= (perr_q & ~clear_flags_i) | bad;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			esusp_q <= 1'b0;
		end else if (do_susp) begin
			esusp_q <= 1'b1;
		end else if (do_resm) begin
			esusp_q <= 1'b0;
		end
	end

	// microsecond timer, frozen while suspended
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick_q <= 4'h0;
			us_q <= 32'h0000_0000;
			limit_q <= 32'h0000_0000;
		end else if (start) begin
			tick_q <= 4'h0;
			us_q <= 32'h0000_0000;
			limit_q <= lim_sel;
		end else if (busy) begin
			tick_q <= tick ? 4'h0 : 4'(tick_q + 4'h1);
			us_q <= tick ? 32'(us_q + 32'h1) : us_q;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			erase_start_o <= 1'b0;
			erase_kind_o <= 2'h0;
			erase_addr_o <= 24'h00_0000;
			frame_addr_o <= 24'h00_0000;
		end else begin
			erase_start_o <= start;
			frame_addr_o <= shift_q[23:0];
			if (start) begin
				erase_kind_o <= kind_sel;
				erase_addr_o <= shift_q[23:0];
			end
		end
	end

	assign erase_hold_o = susp;
	// both registers stay visible in every state
	always_comb begin
		status_o = 8'h00;
		status_o[sfwle_pkg::STAT_WIP_BIT] = busy;
		status_o[sfwle_pkg::STAT_WEL_BIT] = wel_q;
		flag_status_o = 8'h00;
		flag_status_o[sfwle_pkg::FLAG_READY_BIT] = ~busy;
		flag_status_o[sfwle_pkg::FLAG_ESUSP_BIT] = esusp_q;
		flag_status_o[sfwle_pkg::FLAG_EERR_BIT] = eerr_q;
		flag_status_o[sfwle_pkg::FLAG_PROT_BIT] = perr_q;
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	a_wren_sets: assert property (do_wren |=> wel_q)
		else $error("write enable did not set latch");
	a_wrdi_clears: assert property (do_wrdi |=> !wel_q)
		else $error("write disable did not clear latch");
	a_short_frame: assert property ((sel_rise && !timeout && cnt_q != 6'h08 && cnt_q != 6'h20) |=> $stable(wel_q))
		else $error("bad frame changed latch");
	a_no_wel_ignore: assert property ((sel_rise && !wel_q && idle) |=> idle && !$rose(eerr_q) && !$rose(perr_q))
		else $error("erase ran without latch");
	a_start_busy: assert property (start |=> status_o[0] && !wel_q ##1 erase_start_o == 1'b0)
		else $error("erase start wrong");
	a_start_pulse: assert property (start |=> erase_start_o)
		else $error("no start pulse");
	a_finish_idle: assert property (finish |=> !status_o[0] && flag_status_o[7])
		else $error("busy after finish");
	a_timeout_err: assert property (timeout |=> flag_status_o[5] && !wel_q)
		else $error("timeout not flagged");
	a_prot_refuse: assert property (bad |=> wel_q && flag_status_o[1] && flag_status_o[5] && idle)
		else $error("protected erase not refused");
	a_resume_busy: assert property (do_resm |=> status_o[0] && !flag_status_o[7] && !flag_status_o[6])
		else $error("resume wrong");
	a_susp_hold: assert property (do_susp |=> erase_hold_o && !status_o[0] ##1 $stable(us_q))
		else $error("suspend wrong");

	c_wren: cover property (do_wren);
	c_erase_done: cover property (start ##[1:1000] finish);
	c_refused: cover property (bad);
	c_suspend_resume: cover property (do_susp ##[1:1000] do_resm);
endmodule : sfwle_top

// *** tb/sfwle_host.sv ***
// host model driving select, serial clock and lanes
`timescale 1ns/1ns
module sfwle_host (
	output logic sel_n_o,
	output logic sclk_o,
	output logic [3:0] lane_o
);
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		lane_o = 4'h5;
	end
	// msb first, w lanes per rise; data moves on the fall, clock still outside frames
	task automatic frame(input logic [31:0] data, input int units, input int w);
		logic [31:0] sh;
		sh = data;
		sel_n_o = 1'b0;
		for (int i = 0; i < units; i++) begin
			#400 sclk_o = 1'b0;
			lane_o = sh[31:28] >> (4 - w);
			sh = sh << w;
			#400 sclk_o = 1'b1;
		end
		#400 sclk_o = 1'b0;
		// select rises only after the last unit
		#400 sel_n_o = 1'b1;
		lane_o = ~lane_o;
		#400;
	endtask : frame
endmodule : sfwle_host

// *** tb/testbench.sv ***
// self-checking bench for the write latch and erase logic
`timescale 1ns/1ns
module testbench;
	logic mclk, rstn, prot, locked, done, clr, start, hold;
	logic [1:0] proto, kind;
	logic [3:0] lane;
	logic sel_n, sclk;
	logic [23:0] eaddr, faddr;
	logic [7:0] status, flags;
	int error_cnt = 0;
	int num_checks = 0;
	int starts = 0;
	sfwle_host host (.sel_n_o(sel_n), .sclk_o(sclk), .lane_o(lane));
	sfwle_top #(.SSE_LIMIT_US(20), .SE_LIMIT_US(20), .BE_LIMIT_US(20)) uut (
		.mclk_i(mclk), .rstn_i(rstn), .sel_n_i(sel_n), .sclk_i(sclk), .serial_lane_i(lane),
		.protocol_i(proto), .target_protected_i(prot), .any_sector_locked_i(locked),
		.array_done_i(done), .clear_flags_i(clr), .erase_start_o(start), .erase_kind_o(kind),
		.erase_addr_o(eaddr), .erase_hold_o(hold), .frame_addr_o(faddr), .status_o(status),
		.flag_status_o(flags));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) if (start === 1'b1) starts++;
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask : tick
	task automatic regs(input logic [7:0] st, input logic [7:0] fl);
		chk({16'h0, status}, {16'h0, st}, "status");
		chk({16'h0, flags}, {16'h0, fl}, "flags");
	endtask : regs
	task automatic cmd(input logic [7:0] code, input int p, input int extra);
		proto = p[1:0];
		host.frame({code, 24'h0}, 8 / (1 << p) + extra, 1 << p);
		tick(6);
	endtask : cmd
	task automatic erase(input logic [7:0] code, input logic [23:0] addr, input int units);
		proto = 2'h0;
		host.frame({code, addr}, units, 1);
		tick(6);
	endtask : erase
	task automatic pulse_done;
		done = 1'b1;
		tick(1);
		done = 1'b0;
		tick(2);
	endtask : pulse_done
	task automatic clear;
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(1);
	endtask : clear
	task automatic t_latch;
		for (int p = 0; p < 3; p++) begin
			cmd(sfwle_pkg::CMD_WREN, p, 0);
			regs(8'h02, 8'h80);
			cmd(sfwle_pkg::CMD_WRDI, p, 0);
			regs(8'h00, 8'h80);
		end
		$display("test latch done");
	endtask : t_latch
	task automatic t_noraise;
		cmd(sfwle_pkg::CMD_WREN, 0, 1);
		regs(8'h00, 8'h80);
		cmd(sfwle_pkg::CMD_WREN, 0, 0);
		cmd(sfwle_pkg::CMD_WRDI, 0, 1);
		regs(8'h02, 8'h80);
		erase(sfwle_pkg::CMD_SSE_DEF, 24'h000040, 33);
		regs(8'h02, 8'h80);
		cmd(sfwle_pkg::CMD_WRDI, 0, 0);
		erase(sfwle_pkg::CMD_SE_DEF, 24'h020000, 32);
		regs(8'h00, 8'h80);
		$display("test no raise done");
	endtask : t_noraise
	task automatic t_erase;
		int s;
		for (int k = 0; k < 3; k++) begin
			s = starts;
			cmd(sfwle_pkg::CMD_WREN, 0, 0);
			if (k == 2) cmd(sfwle_pkg::CMD_BE_DEF, 0, 0);
			else erase(k == 0 ? sfwle_pkg::CMD_SSE_DEF : sfwle_pkg::CMD_SE_DEF, 24'h3a5c71 + 24'(k), 32);
			regs(8'h01, 8'h00);
			chk(24'(starts - s), 24'h1, "start");
			chk({22'h0, kind}, 24'(k), "kind");
			if (k < 2) chk(eaddr, 24'h3a5c71 + 24'(k), "address");
			if (k < 2) chk(faddr, 24'h3a5c71 + 24'(k), "frame address");
			pulse_done;
			regs(8'h00, 8'h80);
		end
		$display("test erase done");
	endtask : t_erase
	task automatic t_fail;
		int s;
		cmd(sfwle_pkg::CMD_WREN, 0, 0);
		erase(sfwle_pkg::CMD_SE_DEF, 24'h0f0000, 32);
		tick(260);
		regs(8'h00, 8'ha0);
		clear;
		s = starts;
		prot = 1'b1;
		cmd(sfwle_pkg::CMD_WREN, 0, 0);
		erase(sfwle_pkg::CMD_SSE_DEF, 24'h001000, 32);
		regs(8'h02, 8'ha2);
		prot = 1'b0;
		clear;
		locked = 1'b1;
		cmd(sfwle_pkg::CMD_BE_DEF, 0, 0);
		regs(8'h02, 8'ha2);
		chk(24'(starts - s), 24'h0, "refused start");
		locked = 1'b0;
		clear;
		$display("test fail done");
	endtask : t_fail
	task automatic t_suspend;
		erase(sfwle_pkg::CMD_SSE_DEF, 24'h000100, 32);
		cmd(sfwle_pkg::CMD_SUSP_DEF, 0, 0);
		regs(8'h00, 8'hc0);
		chk({23'h0, hold}, 24'h1, "hold");
		cmd(sfwle_pkg::CMD_RESM_DEF, 0, 0);
		regs(8'h01, 8'h00);
		chk({23'h0, hold}, 24'h0, "hold");
		pulse_done;
		regs(8'h00, 8'h80);
		$display("test suspend done");
	endtask : t_suspend
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	initial begin
		rstn = 1'b0;
		proto = 2'h0;
		prot = 1'b0;
		locked = 1'b0;
		done = 1'b0;
		clr = 1'b0;
		repeat (16) @(posedge mclk);
		#5 rstn = 1'b1;
		tick(4);
		regs(8'h00, 8'h80);
		t_latch;
		t_noraise;
		t_erase;
		t_fail;
		cmd(sfwle_pkg::CMD_WREN, 0, 0);
		t_suspend;
		wrap_up;
	end
	// generous: the whole sequence needs well under a millisecond
	initial begin
		#3000000;
		error_cnt++;
		wrap_up;
	end
endmodule : testbench
